/* File: rtl/dlb_pkg.sv */
// Package: constants and carrier types of the diagnostic LED blink generator
package dlb_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DLB_ADR_W  = 8;
    localparam int DLB_DAT_W  = 32;
    localparam int DLB_CNT_W  = 4;
    localparam int DLB_TMR_W  = 10;
    localparam int DLB_TICK_W = 16;
    localparam int DLB_NOUT   = 10;
    localparam int DLB_NIRQ   = 3;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DLB_ADR_IRQ_STAT  = 8'h00;
    localparam logic [7:0] DLB_ADR_IRQ_CLR   = 8'h04;
    localparam logic [7:0] DLB_ADR_IRQ_EN    = 8'h08;
    localparam logic [7:0] DLB_ADR_FAULT     = 8'h0C;
    localparam logic [7:0] DLB_ADR_CPU_CODE  = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DLB_IRQ_COMM    = 0;
    localparam int DLB_IRQ_OUT     = 1;
    localparam int DLB_IRQ_INT     = 2;
    localparam int DLB_FLT_MULTI   = 10;
    localparam int DLB_FLT_SINGLE  = 11;
    localparam int DLB_FLT_SHUT    = 12;
    localparam int DLB_CPU_CODE_LO = 4;

    // ------------------------------------------------------------
    // Blink counts
    // ------------------------------------------------------------
    localparam logic [3:0] DLB_CODE_NONE   = 4'h0;
    localparam logic [3:0] DLB_CODE_MULTI  = 4'h1;
    localparam logic [3:0] DLB_CODE_SINGLE = 4'h3;

    // ------------------------------------------------------------
    // Default timing: divider length in clock cycles, phases in divider ticks
    // ------------------------------------------------------------
    localparam int DLB_TICK_CYC    = 25000;
    localparam int DLB_FLICK_TICKS = 25;
    localparam int DLB_FLICK_TOG   = 20;
    localparam int DLB_PULSE_TICKS = 250;
    localparam int DLB_GAP_TICKS   = 500;

    // ------------------------------------------------------------
    // Sequencer and top-level state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_FLICK,
        SEQ_GAP_A,
        SEQ_PULSE_A,
        SEQ_GAP_B,
        SEQ_PULSE_B,
        SEQ_GAP_END
    } dlb_seq_st_type;

    typedef struct packed {
        dlb_seq_st_type         st;
        logic [DLB_TMR_W-1:0]   tmr;
        logic [DLB_TMR_W-1:0]   num;
        logic [DLB_CNT_W-1:0]   a;
        logic [DLB_CNT_W-1:0]   b;
        logic                   led;
    } dlb_seq_type;

    typedef struct packed {
        logic [2:0]             sync;
        logic                   ack_lvl;
        logic                   multi;
        logic                   single;
        logic [DLB_NOUT-1:0]    out_lat;
        logic                   cpu1;
        logic                   cpu2;
        logic [DLB_CNT_W-1:0]   ecode;
        logic [DLB_CNT_W-1:0]   earg;
        logic [DLB_TICK_W-1:0]  tick_cnt;
        logic                   tick;
        logic [DLB_NIRQ-1:0]    irq_stat;
        logic [DLB_NIRQ-1:0]    irq_en;
        logic                   ack;
        logic [DLB_DAT_W-1:0]   dat;
        logic                   comm_led;
        logic                   out_led;
        logic                   int_led;
        logic                   code_led;
        logic                   irq;
        logic                   outs_en;
    } dlb_top_type;

endpackage

/* File: rtl/dlb_seq.sv */
// Blink sequencer: flicker start marker, then one or two slow pulse groups
`timescale 1ns/10ps
module dlb_seq
    import dlb_pkg::*;
#(
    parameter int FLICK_TICKS = DLB_FLICK_TICKS,
    parameter int FLICK_TOG   = DLB_FLICK_TOG,
    parameter int PULSE_TICKS = DLB_PULSE_TICKS,
    parameter int GAP_TICKS   = DLB_GAP_TICKS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 tick_i,
    input  wire logic                 run_i,
    input  wire logic [DLB_CNT_W-1:0] cnt_a_i,
    input  wire logic [DLB_CNT_W-1:0] cnt_b_i,
    output logic                      led_o
);

    localparam logic [DLB_TMR_W-1:0] FLK = DLB_TMR_W'(FLICK_TICKS);
    localparam logic [DLB_TMR_W-1:0] TOG = DLB_TMR_W'(FLICK_TOG);
    localparam logic [DLB_TMR_W-1:0] PLS = DLB_TMR_W'(PULSE_TICKS);
    localparam logic [DLB_TMR_W-1:0] GAP = DLB_TMR_W'(GAP_TICKS);
    localparam logic [DLB_TMR_W-1:0] ONE = DLB_TMR_W'(1);

    dlb_seq_type s_q;
    dlb_seq_type s_d;
    logic        expire;

    assign expire = tick_i && (s_q.tmr <= ONE);
    assign led_o  = s_q.led;

    // ------------------------------------------------------------
    // Sequence engine
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (!run_i) begin
            s_d.st  = SEQ_IDLE;
            s_d.led = 1'b0;
        end else if (s_q.st == SEQ_IDLE) begin
            s_d.st  = SEQ_FLICK;                                   // [R13]
            s_d.tmr = FLK;                                         // [R15]
            s_d.num = TOG;
            s_d.a   = cnt_a_i;
            s_d.b   = cnt_b_i;
            s_d.led = 1'b1;
        end else if (tick_i && !expire) begin
            s_d.tmr = s_q.tmr - ONE;
        end else if (expire) begin
            unique case (s_q.st)
                SEQ_FLICK: begin
                    if (s_q.num <= ONE) begin
                        s_d.st  = SEQ_GAP_A;                       // [R13]
                        s_d.led = 1'b0;
                        s_d.tmr = GAP;
                    end else begin
                        s_d.num = s_q.num - ONE;
                        s_d.led = ~s_q.led;
                        s_d.tmr = FLK;
                    end
                end
                SEQ_GAP_A, SEQ_GAP_B: begin
                    s_d.st  = (s_q.st == SEQ_GAP_A) ? SEQ_PULSE_A : SEQ_PULSE_B;
                    s_d.num = DLB_TMR_W'((s_q.st == SEQ_GAP_A) ? s_q.a : s_q.b);
                    s_d.led = 1'b1;
                    s_d.tmr = PLS;
                end
                SEQ_PULSE_A, SEQ_PULSE_B: begin
                    if (s_q.led) begin
                        s_d.led = 1'b0;
                        if (s_q.num <= ONE) begin
                            s_d.st  = (s_q.st == SEQ_PULSE_A && s_q.b != DLB_CODE_NONE) ?
                                      SEQ_GAP_B : SEQ_GAP_END;     // [R13]
                            s_d.tmr = GAP;
                        end else begin
                            s_d.tmr = PLS;
                        end
                    end else begin
                        s_d.led = 1'b1;
                        s_d.num = s_q.num - ONE;
                        s_d.tmr = PLS;
                    end
                end
                SEQ_GAP_END: begin
                    s_d.st  = SEQ_FLICK;                           // [R14]
                    s_d.tmr = FLK;
                    s_d.num = TOG;
                    s_d.a   = cnt_a_i;
                    s_d.b   = cnt_b_i;
                    s_d.led = 1'b1;
                end
                default: begin
                    s_d.st  = SEQ_IDLE;
                    s_d.led = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_flick_then_gap: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
        (run_i && expire && s_q.st == SEQ_FLICK && s_q.num <= ONE)
        |=> (s_q.st == SEQ_GAP_A && !led_o))
        else $error("flicker did not end in a dark gap");

    chk_seq_restart: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        (run_i && expire && s_q.st == SEQ_GAP_END)
        |=> (s_q.st == SEQ_FLICK && led_o))
        else $error("sequence did not restart with flicker");

endmodule

/* File: rtl/dlb_top.sv */
// Top: diagnostic LED blink code generator with Wishbone registers
`timescale 1ns/10ps
// Function
// (R1) Comm LED steady when link healthy
// (R2) Multiple connections down: flicker plus one pulse
// (R3) Single connection down: flicker plus three
// (R4) Ack falling edge clears comm errors
// (R5) Channel n current fault: n pulses
// (R6) Field voltage low 5, high 6
// (R7) Temperature low 7, high 8
// (R8) Temperature difference: 9 pulses
// (R9) Output circuit fault: 10 pulses
// (R10) Output faults held until power cycle
// (R11) Internal fault LED; code LED shows source; code LED stays dark when only the second supervisor CPU faults
// (R12) Processor fault forces permanent output shutdown
// (R13) Code: flicker, error code, error argument
// (R14) Code sequence repeats from flicker forever
// (R15) Blink timing set by parameters
// (R16) Lowest active output code shown first
module dlb_top
    import dlb_pkg::*;
#(
    parameter int TICK_CYC    = DLB_TICK_CYC,
    parameter int FLICK_TICKS = DLB_FLICK_TICKS,
    parameter int FLICK_TOG   = DLB_FLICK_TOG,
    parameter int PULSE_TICKS = DLB_PULSE_TICKS,
    parameter int GAP_TICKS   = DLB_GAP_TICKS
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [DLB_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [DLB_DAT_W-1:0]  wb_dat_i,
    output logic [DLB_DAT_W-1:0]       wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  conn_multi_fault_i,
    input  wire logic                  conn_single_fault_i,
    input  wire logic                  err_ack_i,
    input  wire logic [3:0]            chan_current_fault_i,
    input  wire logic                  field_volt_low_i,
    input  wire logic                  field_volt_high_i,
    input  wire logic                  temp_low_i,
    input  wire logic                  temp_high_i,
    input  wire logic                  temp_diff_i,
    input  wire logic                  out_circuit_fault_i,
    input  wire logic                  first_supervisor_cpu_fault_i,
    input  wire logic                  second_supervisor_cpu_fault_i,
    input  wire logic [DLB_CNT_W-1:0]  cpu_err_code_i,
    input  wire logic [DLB_CNT_W-1:0]  cpu_err_arg_i,
    output logic                       comm_status_led_o,
    output logic                       output_status_led_o,
    output logic                       internal_fault_led_o,
    output logic                       fault_code_led_o,
    output logic                       outputs_enable_o,
    output logic                       irq_o
);

    localparam logic [DLB_TICK_W-1:0] TICK_LAST = DLB_TICK_W'(TICK_CYC - 1);

    // ------------------------------------------------------------
    // Lowest active output fault code
    // ------------------------------------------------------------
    function automatic logic [DLB_CNT_W-1:0] lowest_code(input logic [DLB_NOUT-1:0] f);
        logic [DLB_CNT_W-1:0] c;
        c = DLB_CODE_NONE;
        for (int i = DLB_NOUT - 1; i >= 0; i--) begin
            if (f[i]) begin
                c = DLB_CNT_W'(i + 1);
            end
        end
        return c;
    endfunction

    dlb_top_type          t_q;
    dlb_top_type          t_d;
    logic                 ack_fall;
    logic                 comm_run;
    logic [DLB_CNT_W-1:0] comm_cnt;
    logic [DLB_CNT_W-1:0] out_cnt;
    logic [DLB_NOUT-1:0]  out_now;
    logic [DLB_NIRQ-1:0]  irq_ev;
    logic                 comm_seq_led;
    logic                 out_seq_led;
    logic                 code_seq_led;
    logic                 wr_hit;
    logic [DLB_DAT_W-1:0] rd_val;

    // ------------------------------------------------------------
    // Fault decode
    // ------------------------------------------------------------
    assign out_now  = {out_circuit_fault_i, temp_diff_i, temp_high_i, temp_low_i,
                       field_volt_high_i, field_volt_low_i, chan_current_fault_i};
    assign ack_fall = t_q.ack_lvl && !t_q.sync[1] && !t_q.sync[2];              // [R4]
    assign comm_run = t_q.multi || t_q.single;
    assign comm_cnt = t_q.multi ? DLB_CODE_MULTI : DLB_CODE_SINGLE;             // [R2] [R3]
    assign out_cnt  = lowest_code(t_q.out_lat);                                 // [R16]
    assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && t_q.ack && wb_sel_i[0];

    always_comb begin
        rd_val = '0;
        unique case (wb_adr_i)
            DLB_ADR_IRQ_STAT: rd_val[DLB_NIRQ-1:0] = t_q.irq_stat;
            DLB_ADR_IRQ_EN:   rd_val[DLB_NIRQ-1:0] = t_q.irq_en;
            DLB_ADR_FAULT: begin
                rd_val[DLB_NOUT-1:0]  = t_q.out_lat;
                rd_val[DLB_FLT_MULTI]  = t_q.multi;
                rd_val[DLB_FLT_SINGLE] = t_q.single;
                rd_val[DLB_FLT_SHUT]   = t_q.cpu1 || t_q.cpu2;
            end
            DLB_ADR_CPU_CODE: begin
                rd_val[DLB_CNT_W-1:0] = t_q.earg;
                rd_val[DLB_CPU_CODE_LO +: DLB_CNT_W] = t_q.ecode;
            end
            default: rd_val = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        t_d = t_q;
        t_d.sync = {t_q.sync[1:0], err_ack_i};
        if (t_q.sync[1] == t_q.sync[2]) begin
            t_d.ack_lvl = t_q.sync[2];
        end
        t_d.multi  = conn_multi_fault_i || (t_q.multi && !ack_fall);           // [R2] [R4]
        t_d.single = conn_single_fault_i || (t_q.single && !ack_fall);         // [R3] [R4]
        t_d.out_lat = t_q.out_lat | out_now;                                    // [R10]
        t_d.cpu1 = t_q.cpu1 || first_supervisor_cpu_fault_i;                    // [R12]
        t_d.cpu2 = t_q.cpu2 || second_supervisor_cpu_fault_i;                   // [R12]
        if (first_supervisor_cpu_fault_i && !t_q.cpu1) begin
            t_d.ecode = cpu_err_code_i;
            t_d.earg  = cpu_err_arg_i;
        end
        // Tick divider
        t_d.tick = 1'b0;
        if (t_q.tick_cnt >= TICK_LAST) begin
            t_d.tick_cnt = '0;
            t_d.tick     = 1'b1;
        end else begin
            t_d.tick_cnt = t_q.tick_cnt + DLB_TICK_W'(1);
        end
        // Events and interrupt
        irq_ev = '0;
        irq_ev[DLB_IRQ_COMM] = t_d.multi && !t_q.multi || t_d.single && !t_q.single;
        irq_ev[DLB_IRQ_OUT]  = |(out_now & ~t_q.out_lat);
        irq_ev[DLB_IRQ_INT]  = (t_d.cpu1 || t_d.cpu2) && !(t_q.cpu1 || t_q.cpu2);
        t_d.irq_stat = t_q.irq_stat | irq_ev;
        if (wr_hit && wb_adr_i == DLB_ADR_IRQ_CLR) begin
            t_d.irq_stat = (t_q.irq_stat & ~wb_dat_i[DLB_NIRQ-1:0]) | irq_ev;
        end
        if (wr_hit && wb_adr_i == DLB_ADR_IRQ_EN) begin
            t_d.irq_en = wb_dat_i[DLB_NIRQ-1:0];
        end
        t_d.irq = |(t_q.irq_stat & t_q.irq_en);
        // Wishbone slave
        t_d.ack = wb_cyc_i && wb_stb_i && !t_q.ack;
        t_d.dat = rd_val;
        // LEDs and output gate
        t_d.comm_led = comm_run ? comm_seq_led : 1'b1;                          // [R1]
        t_d.out_led  = out_seq_led;
        t_d.int_led  = t_q.cpu1 || t_q.cpu2;                                    // [R11]
        t_d.code_led = t_q.cpu1 && code_seq_led;                                // [R11]
        t_d.outs_en  = !(t_q.cpu1 || t_q.cpu2);                                 // [R12]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign wb_ack_o             = t_q.ack;
    assign wb_dat_o             = t_q.dat;
    assign comm_status_led_o    = t_q.comm_led;
    assign output_status_led_o  = t_q.out_led;
    assign internal_fault_led_o = t_q.int_led;
    assign fault_code_led_o     = t_q.code_led;
    assign outputs_enable_o     = t_q.outs_en;
    assign irq_o                = t_q.irq;

    // ------------------------------------------------------------
    // Sequencers
    // ------------------------------------------------------------
    dlb_seq #(
        .FLICK_TICKS (FLICK_TICKS),
        .FLICK_TOG   (FLICK_TOG),
        .PULSE_TICKS (PULSE_TICKS),
        .GAP_TICKS   (GAP_TICKS)
    ) u_comm_seq (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (t_q.tick),
        .run_i   (comm_run),
        .cnt_a_i (comm_cnt),
        .cnt_b_i (DLB_CODE_NONE),
        .led_o   (comm_seq_led)
    );

    dlb_seq #(
        .FLICK_TICKS (FLICK_TICKS),
        .FLICK_TOG   (FLICK_TOG),
        .PULSE_TICKS (PULSE_TICKS),
        .GAP_TICKS   (GAP_TICKS)
    ) u_out_seq (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (t_q.tick),
        .run_i   (|t_q.out_lat),                                               // [R5]
        .cnt_a_i (out_cnt),                                                     // [R6] [R7]
        .cnt_b_i (DLB_CODE_NONE),                                               // [R8] [R9]
        .led_o   (out_seq_led)
    );

    dlb_seq #(
        .FLICK_TICKS (FLICK_TICKS),
        .FLICK_TOG   (FLICK_TOG),
        .PULSE_TICKS (PULSE_TICKS),
        .GAP_TICKS   (GAP_TICKS)
    ) u_code_seq (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (t_q.tick),
        .run_i   (t_q.cpu1),
        .cnt_a_i (t_q.ecode),                                                   // [R13]
        .cnt_b_i (t_q.earg),
        .led_o   (code_seq_led)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_comm_steady_on: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        (!rst_i && !t_q.multi && !t_q.single) |=> comm_status_led_o)
        else $error("comm LED not steady while healthy");

    chk_comm_multi_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        conn_multi_fault_i |=> (t_q.multi && comm_cnt == DLB_CODE_MULTI))
        else $error("multi connection fault not shown as one pulse");

    chk_comm_single_cnt: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        (t_q.single && !t_q.multi) |-> comm_cnt == DLB_CODE_SINGLE)
        else $error("single connection fault not three pulses");

    chk_ack_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        (ack_fall && !conn_multi_fault_i && !conn_single_fault_i)
        |=> (!t_q.multi && !t_q.single))
        else $error("ack falling edge did not clear comm errors");

    chk_chan_code: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        chan_current_fault_i[0] |=> out_cnt == 4'h1)
        else $error("channel 1 fault not shown first");

    chk_field_code: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
        (t_q.out_lat[5:0] == 6'h20) |-> out_cnt == 4'h6)
        else $error("field voltage high code wrong");

    chk_out_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        ##1 ((t_q.out_lat & $past(t_q.out_lat)) == $past(t_q.out_lat)))
        else $error("output fault released before power cycle");

    chk_code_led_dark: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        (t_q.cpu2 && !t_q.cpu1) |=> (!fault_code_led_o && internal_fault_led_o))
        else $error("second cpu fault shown wrongly");

    chk_shutdown: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        (first_supervisor_cpu_fault_i || second_supervisor_cpu_fault_i)
        |-> ##2 !outputs_enable_o[*3])
        else $error("outputs not shut down after cpu fault");

    chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing wrong");

    cov_comm_blink: cover property (@(posedge clk_i) disable iff (rst_i)
        t_q.multi ##1 ack_fall);
    cov_out_fault: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(|t_q.out_lat));
    cov_cpu_fault: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(t_q.cpu1) ##[1:50] fault_code_led_o);

endmodule

/* File: verif/dlb_led_reader.sv */
// LED observer model: decodes flicker marker plus slow pulse groups
`timescale 1ns/10ps
module dlb_led_reader (
    input  wire logic        clk_i,
    input  wire logic        led_i,
    output logic [3:0]       a_o,
    output logic [3:0]       b_o,
    output logic [15:0]      n_o,
    output logic             steady_o
);
    logic       led_q;
    int         hi;
    int         lo;
    int         cur;
    int         g;
    logic [3:0] a;
    logic [3:0] b;
    initial begin
        {led_q, hi, lo, cur, g, a, b, a_o, b_o, n_o} = '0;
    end
    assign steady_o = (hi > 40);
    always @(posedge clk_i) begin
        led_q <= led_i;
        hi <= led_i ? hi + 1 : 0;
        lo <= led_i ? 0 : lo + 1;
        if (led_q && !led_i) begin
            if (hi > 2 && hi < 20) begin
                cur <= cur + 1;
            end else if (hi <= 2 && g > 0) begin
                a_o <= a;
                b_o <= (g > 1) ? b : 4'h0;
                n_o <= n_o + 16'h1;
                g <= 0;
            end
        end
        if (!led_i && lo == 6 && cur > 0) begin
            if (g == 0) a <= cur[3:0];
            else b <= cur[3:0];
            g <= g + 1;
            cur <= 0;
        end
    end
endmodule

/* File: verif/tb.sv */
// Testbench: blink codes, fault latching, interrupts and shutdown
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
    import dlb_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, multi = 0, single = 0, eack = 0;
    logic cpu1 = 0, cpu2 = 0, ack, irq, oen, intl;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = '0, rdat, r;
    logic [9:0]  flt = '0;
    logic [3:0]  ecode = '0, earg = '0;
    logic [2:0]  leds;
    wire  [3:0]  ga [3];
    wire  [3:0]  gb [3];
    wire  [15:0] gn [3];
    wire         st [3];
    int          fail_count = 0, checks = 0, cyc_cnt = 0, k;
    always #20 clk_i = ~clk_i;
    dlb_top #(.TICK_CYC(2), .FLICK_TICKS(1), .FLICK_TOG(4), .PULSE_TICKS(2), .GAP_TICKS(4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .conn_multi_fault_i(multi), .conn_single_fault_i(single), .err_ack_i(eack),
        .chan_current_fault_i(flt[3:0]), .field_volt_low_i(flt[4]), .field_volt_high_i(flt[5]),
        .temp_low_i(flt[6]), .temp_high_i(flt[7]), .temp_diff_i(flt[8]),
        .out_circuit_fault_i(flt[9]), .first_supervisor_cpu_fault_i(cpu1),
        .second_supervisor_cpu_fault_i(cpu2), .cpu_err_code_i(ecode), .cpu_err_arg_i(earg),
        .comm_status_led_o(leds[0]), .output_status_led_o(leds[1]),
        .internal_fault_led_o(intl), .fault_code_led_o(leds[2]),
        .outputs_enable_o(oen), .irq_o(irq));
    for (genvar i = 0; i < 3; i++) begin : g_rd
        dlb_led_reader rd_u (.clk_i(clk_i), .led_i(leds[i]), .a_o(ga[i]), .b_o(gb[i]),
            .n_o(gn[i]), .steady_o(st[i]));
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk_i);
    endtask
    task automatic wseq(input int i);
        int n0, t;
        n0 = gn[i];
        t = 0;
        while (gn[i] < n0 + 2 && t < 3000) begin @(posedge clk_i); t++; end
        `CHK("sequence seen", 1'b1, t < 3000)
    endtask
    task automatic ack_pulse();
        eack <= 1; repeat (5) @(posedge clk_i);
        eack <= 0; repeat (8) @(posedge clk_i);
    endtask
    task automatic do_reset();
        rst_i <= 1; repeat (5) @(posedge clk_i);
        rst_i <= 0; repeat (2) @(posedge clk_i);
    endtask
    initial begin
        do_reset();
        repeat (60) @(posedge clk_i);
        `CHK("comm steady", 1'b1, st[0])
        multi <= 1; @(posedge clk_i); multi <= 0;
        wseq(0);
        `CHK("comm pulses", 4'h1, ga[0])
        ack_pulse(); repeat (60) @(posedge clk_i);
        `CHK("comm steady after ack", 1'b1, st[0])
        single <= 1; @(posedge clk_i); single <= 0;
        wseq(0);
        `CHK("comm pulses", 4'h3, ga[0])
        ack_pulse();
        $display("test comm done");
        wb(1, DLB_ADR_IRQ_EN, 32'h2);
        sel <= 4'h0;
        wb(1, DLB_ADR_IRQ_EN, 32'h7);
        sel <= 4'hF;
        wb(0, DLB_ADR_IRQ_EN, 32'h0);
        `CHK("irq enable lane0 off", 32'h2, r)
        for (k = 10; k >= 1; k--) begin
            flt[k-1] <= 1; @(posedge clk_i); flt <= '0;
            wseq(1);
            `CHK("out pulses", k[3:0], ga[1])
        end
        ack_pulse(); wseq(1);
        `CHK("out held", 4'h1, ga[1])
        wb(0, DLB_ADR_FAULT, 32'h0);
        `CHK("fault reg", 32'h3FF, r)
        `CHK("irq", 1'b1, irq)
        wb(0, DLB_ADR_IRQ_STAT, 32'h0);
        `CHK("status out bit", 1'b1, r[1])
        wb(1, DLB_ADR_IRQ_CLR, 32'h2); repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq)
        wb(0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, r)
        $display("test output done");
        do_reset();
        cpu2 <= 1; repeat (300) @(posedge clk_i); cpu2 <= 0; repeat (5) @(posedge clk_i);
        `CHK("int led", 1'b1, intl)
        `CHK("code led off", 1'b0, leds[2])
        `CHK("outputs off", 1'b0, oen)
        do_reset();
        `CHK("outputs on", 1'b1, oen)
        ecode <= 4'h3; earg <= 4'h2; cpu1 <= 1; @(posedge clk_i); cpu1 <= 0;
        wseq(2);
        `CHK("code group", 4'h3, ga[2])
        `CHK("arg group", 4'h2, gb[2])
        `CHK("outputs off", 1'b0, oen)
        $display("test cpu done");
        end_sim();
    end
endmodule
